// ==== src/eisv_pkg.sv ====
// Purpose: Shared constants for the external interrupt sense and vector select block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes: Register indices are word indices; byte address is four times the index.
package eisv_pkg;

  // Register word indices
  localparam logic [7:0] IDX_MCU_GENERAL_CONTROL = 8'h55;
  localparam logic [7:0] IDX_EXT_IRQ_SENSE_LOW = 8'h69;
  localparam logic [7:0] IDX_EXT_IRQ_SENSE_HIGH = 8'h6a;
  localparam logic [7:0] IDX_EXT_IRQ_MASK = 8'h3d;
  localparam logic [7:0] IDX_EXT_IRQ_FLAGS = 8'h3c;
  localparam logic [7:0] IDX_PIN_CHANGE_MASK_ZERO = 8'h6b;
  localparam logic [7:0] IDX_PIN_CHANGE_MASK_ONE = 8'h6c;
  localparam logic [7:0] IDX_PIN_CHANGE_FLAGS = 8'h3b;

  // Field positions in the general control register
  localparam int BIT_VECTOR_CHANGE_ENABLE = 0;
  localparam int BIT_VECTOR_BASE_SELECT = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Sense control field encodings
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_EDGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;

  // Change-enable window, in CPU cycles
  localparam logic [2:0] VCE_WINDOW = 3'h4;

  // Pin counts and interrupt identifiers
  localparam int NUM_EXT = 8;
  localparam int NUM_ASYNC_EDGE = 4;
  localparam int NUM_PC = 9;
  localparam int NUM_IRQ = 10;
  localparam logic [3:0] ID_PC_ZERO = 4'h8;
  localparam logic [3:0] ID_PC_ONE = 4'h9;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Vector change sequence states
  typedef enum logic [2:0] {
    VCS_IDLE = 3'b001,
    VCS_ARMED = 3'b010,
    VCS_TRAIL = 3'b100
  } eisv_vcs_t;

endpackage

// ==== src/eisv_sync.sv ====
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Inputs may change at any time relative to the clock.
// Notes: The first stage is read only by the second stage.
module eisv_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two flops in series; reset to all low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== src/eisv_top.sv ====
// Purpose: External pin interrupt sense, pin change groups and vector base select.
// Assumes: Pins are asynchronous; CPU handshakes arrive on REF_CLK.
// Notes: Asynchronous capture during sleep is modelled by the synchronised path.
//
// Overview of operation
// - Vector base is zero, or boot section start when base select is one.
// - Interrupts blocked from change enable until instruction after select write.
// - Automatic blocking never alters the global interrupt enable flag.
// - Change enable clears four cycles after setting or on base select write.
// - Lock bits block interrupts while running code of the other section.
// - Group zero fires on enabled lines 7:0 toggling, group one on line 8.
// - Two mask registers pick which pin change lines feed each group.
// - Pin activity triggers interrupts even when pins drive as outputs.
// - Pin change detection also raises wake-up without the I/O clock.
// - Edges on pins 7:4 need I/O clock; level and pins 3:0 do not.
// - An enabled level interrupt keeps requesting while the pin stays low.
// - Level gone before start-up ends gives wake-up but no interrupt.
// - External interrupts are taken only with global enable and mask bit set.
// - Pulses wider than about 50 ns on pins 3:0 produce an interrupt.
// - Sense code 0 low level, 1 any edge, 2 falling, 3 rising.
// - Low sense register holds pins 3..0 at bits 7:6, 5:4, 3:2, 1:0.
// - Edge sets flag; cleared by acknowledge or writing one; level reads zero.
// - Mask bit one with global enable set enables that pin interrupt.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module eisv_top
  import eisv_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PC_WORD_W = 16,
  parameter logic [PC_WORD_W-1:0] BOOT_BASE_WORDS = 16'h0200
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [eisv_pkg::NUM_EXT-1:0] EXT_REQUEST_PINS,
  input wire logic [eisv_pkg::NUM_PC-1:0] PIN_CHANGE_LINES,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IO_CLK_RUN,
  input wire logic INSTR_DONE,
  input wire logic EXEC_IN_BOOT,
  input wire logic APPLICATION_LOCK_BIT,
  input wire logic BOOT_LOCK_BIT,
  input wire logic [1:0] BOOT_SIZE_SETTING,
  input wire logic IRQ_ACK,
  input wire logic [3:0] IRQ_ACK_ID,
  output logic [eisv_pkg::NUM_IRQ-1:0] IRQ_PENDING,
  output logic IRQ_BLOCKED,
  output logic WAKE_REQUEST,
  output logic [PC_WORD_W-1:0] VECTOR_BASE_ADDR
);

  // Edge test for one pin under its sense control field
  function automatic logic edge_hit(input logic [1:0] sense, input logic cur,
                                    input logic prev);
    unique case (sense)
      SENSE_ANY_EDGE: edge_hit = cur ^ prev;
      SENSE_FALLING: edge_hit = prev & ~cur;
      SENSE_RISING: edge_hit = cur & ~prev;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Word index hit for an address with upper bits zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[ADDR_W-1:10] == '0);
  endfunction

  // Boot section start: larger size setting codes give a smaller boot section
  function automatic logic [PC_WORD_W-1:0] boot_start(input logic [1:0] sz);
    logic [PC_WORD_W-1:0] size_words;
    size_words = BOOT_BASE_WORDS << (2'h3 - sz);
    boot_start = ('0 - size_words);
  endfunction

  // Synchronised pins
  logic [NUM_EXT-1:0] ext_sync;
  logic [NUM_PC-1:0] pc_sync;

  // Register state
  logic [7:0] sense_low_reg;
  logic [7:0] sense_high_reg;
  logic [7:0] ext_mask_reg;
  logic [7:0] ext_flags_reg;
  logic [7:0] ext_flags_next;
  logic [7:0] pc_mask0_reg;
  logic pc_mask1_reg;
  logic [1:0] pc_flags_reg;
  logic [1:0] pc_flags_next;
  logic vsel_reg;
  logic [2:0] vce_cnt_reg;
  eisv_vcs_t vcs_reg;
  eisv_vcs_t vcs_next;
  logic [NUM_EXT-1:0] ext_prev_reg;
  logic [NUM_PC-1:0] pc_prev_reg;

  // Bus slave state
  logic aw_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;

  // Pin synchronisers ahead of all flag and request logic
  // two-stage synchronisers
  eisv_sync #(.W(NUM_EXT)) u_ext_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(EXT_REQUEST_PINS),
    .q(ext_sync)
  );

  eisv_sync #(.W(NUM_PC)) u_pc_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d(PIN_CHANGE_LINES),
    .q(pc_sync)
  );

  // Write decode; a write completes once address and data are both held
  wire wr_go = aw_have_reg & w_have_reg & ~BVALID;
  wire wr_en = wr_go & w_strb0_reg;
  wire [7:0] wbyte = w_data_reg[7:0];
  wire hit_mcu_w = reg_hit(aw_addr_reg, IDX_MCU_GENERAL_CONTROL);
  wire hit_sl_w = reg_hit(aw_addr_reg, IDX_EXT_IRQ_SENSE_LOW);
  wire hit_sh_w = reg_hit(aw_addr_reg, IDX_EXT_IRQ_SENSE_HIGH);
  wire hit_msk_w = reg_hit(aw_addr_reg, IDX_EXT_IRQ_MASK);
  wire hit_flg_w = reg_hit(aw_addr_reg, IDX_EXT_IRQ_FLAGS);
  wire hit_pm0_w = reg_hit(aw_addr_reg, IDX_PIN_CHANGE_MASK_ZERO);
  wire hit_pm1_w = reg_hit(aw_addr_reg, IDX_PIN_CHANGE_MASK_ONE);
  wire hit_pfl_w = reg_hit(aw_addr_reg, IDX_PIN_CHANGE_FLAGS);
  wire wr_mapped = hit_mcu_w | hit_sl_w | hit_sh_w | hit_msk_w | hit_flg_w | hit_pm0_w |
                   hit_pm1_w | hit_pfl_w;
  wire mcu_wr = wr_en & hit_mcu_w;
  wire vce_set_wr = mcu_wr & wbyte[BIT_VECTOR_CHANGE_ENABLE];
  wire vsel_wr = mcu_wr & ~wbyte[BIT_VECTOR_CHANGE_ENABLE] & (vcs_reg == VCS_ARMED);

  // Read decode
  wire hit_mcu_r = reg_hit(ARADDR, IDX_MCU_GENERAL_CONTROL);
  wire hit_sl_r = reg_hit(ARADDR, IDX_EXT_IRQ_SENSE_LOW);
  wire hit_sh_r = reg_hit(ARADDR, IDX_EXT_IRQ_SENSE_HIGH);
  wire hit_msk_r = reg_hit(ARADDR, IDX_EXT_IRQ_MASK);
  wire hit_flg_r = reg_hit(ARADDR, IDX_EXT_IRQ_FLAGS);
  wire hit_pm0_r = reg_hit(ARADDR, IDX_PIN_CHANGE_MASK_ZERO);
  wire hit_pm1_r = reg_hit(ARADDR, IDX_PIN_CHANGE_MASK_ONE);
  wire hit_pfl_r = reg_hit(ARADDR, IDX_PIN_CHANGE_FLAGS);
  wire rd_mapped = hit_mcu_r | hit_sl_r | hit_sh_r | hit_msk_r | hit_flg_r | hit_pm0_r |
                   hit_pm1_r | hit_pfl_r;
  wire vce_bit = (vcs_reg == VCS_ARMED);
  wire [7:0] mcu_rd = {6'h00, vsel_reg, vce_bit};
  wire [7:0] rd_byte = ({8{hit_mcu_r}} & mcu_rd) |
                       ({8{hit_sl_r}} & sense_low_reg) |
                       ({8{hit_sh_r}} & sense_high_reg) |
                       ({8{hit_msk_r}} & ext_mask_reg) |
                       ({8{hit_flg_r}} & ext_flags_reg) |
                       ({8{hit_pm0_r}} & pc_mask0_reg) |
                       ({8{hit_pm1_r}} & {7'h00, pc_mask1_reg}) |
                       ({8{hit_pfl_r}} & {6'h00, pc_flags_reg});

  // Sense field of each pin; pins 3..0 low register, 7..4 high register
  // field placement
  wire [15:0] sense_all = {sense_high_reg, sense_low_reg};
  wire [NUM_EXT-1:0] is_level;
  wire [NUM_EXT-1:0] edge_evt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_sense
      assign is_level[gi] = (sense_all[2*gi +: 2] == SENSE_LOW_LEVEL);
      if (gi < NUM_ASYNC_EDGE) begin : g_async
        assign edge_evt[gi] = edge_hit(sense_all[2*gi +: 2], ext_sync[gi], ext_prev_reg[gi]);
      end else begin : g_clocked
        assign edge_evt[gi] = IO_CLK_RUN &
                              edge_hit(sense_all[2*gi +: 2], ext_sync[gi], ext_prev_reg[gi]);
      end
    end
  endgenerate

  // Pin change groups: toggles gated by the line masks
  // group toggle detect
  wire [NUM_PC-1:0] pc_toggle = pc_sync ^ pc_prev_reg;
  wire pc_evt0 = |(pc_toggle[7:0] & pc_mask0_reg);
  wire pc_evt1 = pc_toggle[8] & pc_mask1_reg;

  // Acknowledge decode from the core entering a handler
  wire [15:0] ack_dec = IRQ_ACK ? (16'h0001 << IRQ_ACK_ID) : 16'h0000;

  // Flag update: a hardware set wins over a clear in the same cycle
  // flag set and clear
  wire [7:0] ext_clr = ack_dec[7:0] | ({8{wr_en & hit_flg_w}} & wbyte);
  assign ext_flags_next = ((ext_flags_reg & ~ext_clr) | edge_evt) & ~is_level;
  wire [1:0] pc_clr = {ack_dec[ID_PC_ONE], ack_dec[ID_PC_ZERO]} |
                      ({2{wr_en & hit_pfl_w}} & wbyte[1:0]);
  assign pc_flags_next = (pc_flags_reg & ~pc_clr) | {pc_evt1, pc_evt0};

  // Raw requests; level pins follow the live pin, so a vanished level asks nothing
  // live level request
  wire [NUM_EXT-1:0] ext_src = (is_level & ~ext_sync) | (~is_level & ext_flags_reg);
  wire [NUM_EXT-1:0] ext_req = ext_src & ext_mask_reg;
  wire [NUM_IRQ-1:0] raw_req = {pc_flags_reg[1] & pc_mask1_reg,
                                pc_flags_reg[0] & (|pc_mask0_reg), ext_req};

  // Blocking covers the change sequence and foreign-section execution
  // sequence block
  wire lock_block = (vsel_reg & APPLICATION_LOCK_BIT & ~EXEC_IN_BOOT) |
                    (~vsel_reg & BOOT_LOCK_BIT & EXEC_IN_BOOT);
  wire block_now = vce_set_wr | (vcs_reg != VCS_IDLE) | lock_block;

  // Global enable is only read here, never written, so blocking leaves it alone
  // flag untouched
  wire [NUM_IRQ-1:0] pend_next = raw_req & {NUM_IRQ{GLOBAL_IRQ_ENABLE & ~block_now}};

  // Wake-up does not wait for the global enable or the I/O clock
  // pin change wake
  wire wake_next = pc_evt0 | pc_evt1 | (|(ext_mask_reg & is_level & ~ext_sync)) |
                   (|(ext_mask_reg[NUM_ASYNC_EDGE-1:0] & edge_evt[NUM_ASYNC_EDGE-1:0]));

  // Vector change sequencer; software keeps the four-cycle window
  // relies on timely write
  always_comb begin
    vcs_next = vcs_reg;
    unique case (vcs_reg)
      VCS_IDLE: begin
        if (vce_set_wr) begin
          vcs_next = VCS_ARMED;
        end
      end
      VCS_ARMED: begin
        if (vce_set_wr) begin
          vcs_next = VCS_ARMED;
        end else if (vsel_wr) begin
          vcs_next = VCS_TRAIL;
        end else if (vce_cnt_reg == 3'h1) begin
          vcs_next = VCS_IDLE;
        end
      end
      VCS_TRAIL: begin
        if (INSTR_DONE) begin
          vcs_next = VCS_IDLE;
        end
      end
      default: vcs_next = VCS_IDLE;
    endcase
  end

  // Sequencer state and window count
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      vcs_reg <= VCS_IDLE;
      vce_cnt_reg <= 3'h0;
    end else begin
      vcs_reg <= vcs_next;
      if (vce_set_wr) begin
        vce_cnt_reg <= VCE_WINDOW;
      end else if (vce_cnt_reg != 3'h0) begin
        vce_cnt_reg <= vce_cnt_reg - 3'h1;
      end
    end
  end

  // Software-written registers; base select only moves inside the window
  // base select store
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      vsel_reg <= 1'b0;
      sense_low_reg <= RST_BYTE;
      sense_high_reg <= RST_BYTE;
      ext_mask_reg <= RST_BYTE;
      pc_mask0_reg <= RST_BYTE;
      pc_mask1_reg <= 1'b0;
    end else begin
      if (vsel_wr) begin
        vsel_reg <= wbyte[BIT_VECTOR_BASE_SELECT];
      end
      if (wr_en & hit_sl_w) begin
        sense_low_reg <= wbyte;
      end
      if (wr_en & hit_sh_w) begin
        sense_high_reg <= wbyte;
      end
      if (wr_en & hit_msk_w) begin
        ext_mask_reg <= wbyte;
      end
      if (wr_en & hit_pm0_w) begin
        pc_mask0_reg <= wbyte;
      end
      if (wr_en & hit_pm1_w) begin
        pc_mask1_reg <= wbyte[0];
      end
    end
  end

  // Previous pin samples; upper edge pins freeze while the I/O clock is stopped
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_prev_reg <= '0;
      pc_prev_reg <= '0;
    end else begin
      ext_prev_reg[NUM_ASYNC_EDGE-1:0] <= ext_sync[NUM_ASYNC_EDGE-1:0];
      if (IO_CLK_RUN) begin
        ext_prev_reg[NUM_EXT-1:NUM_ASYNC_EDGE] <= ext_sync[NUM_EXT-1:NUM_ASYNC_EDGE];
      end
      pc_prev_reg <= pc_sync;
    end
  end

  // Flags and registered outputs toward the core
  // pulse capture by sampling
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_flags_reg <= RST_BYTE;
      pc_flags_reg <= 2'h0;
      IRQ_PENDING <= '0;
      IRQ_BLOCKED <= 1'b0;
      WAKE_REQUEST <= 1'b0;
      VECTOR_BASE_ADDR <= '0;
    end else begin
      ext_flags_reg <= ext_flags_next;
      pc_flags_reg <= pc_flags_next;
      IRQ_PENDING <= pend_next;
      IRQ_BLOCKED <= block_now;
      WAKE_REQUEST <= wake_next;
      VECTOR_BASE_ADDR <= vsel_reg ? boot_start(BOOT_SIZE_SETTING) : '0;
    end
  end

  // Write channels: address and data taken independently, held until both present
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      AWREADY <= 1'b1;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      WREADY <= 1'b1;
    end else begin
      if (AWVALID & AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
        AWREADY <= 1'b0;
      end else if (BVALID & BREADY) begin
        aw_have_reg <= 1'b0;
        AWREADY <= 1'b1;
      end
      if (WVALID & WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb0_reg <= WSTRB[0];
        WREADY <= 1'b0;
      end else if (BVALID & BREADY) begin
        w_have_reg <= 1'b0;
        WREADY <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer decode error
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Read channel; reads have no side effects on flags
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ARVALID & ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= {24'h00_0000, rd_byte};
      RRESP <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (RVALID & RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

endmodule

// ==== tb/eisv_checker.sv ====
// Purpose: Port-level checks for bus timing and interrupt gating.
// Assumes: One clock domain; RST is asynchronous and active high.
// Notes: Bound into eisv_top at the foot of this file.
module eisv_checker
  import eisv_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PC_WORD_W = 16,
  parameter logic [PC_WORD_W-1:0] BOOT_BASE_WORDS = 16'h0200
) (
  input logic REF_CLK,
  input logic RST,
  input logic AWVALID,
  input logic AWREADY,
  input logic WVALID,
  input logic WREADY,
  input logic BVALID,
  input logic BREADY,
  input logic ARVALID,
  input logic ARREADY,
  input logic [31:0] RDATA,
  input logic RVALID,
  input logic RREADY,
  input logic GLOBAL_IRQ_ENABLE,
  input logic EXEC_IN_BOOT,
  input logic APPLICATION_LOCK_BIT,
  input logic [1:0] BOOT_SIZE_SETTING,
  input logic [eisv_pkg::NUM_IRQ-1:0] IRQ_PENDING,
  input logic IRQ_BLOCKED,
  input logic [PC_WORD_W-1:0] VECTOR_BASE_ADDR
);
  logic [PC_WORD_W-1:0] boot_start;

  // Boot section start; size must stay fixed while vectors sit there
  assign boot_start = '0 - (BOOT_BASE_WORDS << (2'd3 - BOOT_SIZE_SETTING));

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_taken;
    ARVALID && ARREADY;
  endsequence

  // Both halves are held one edge before the response is raised
  a_write_answer: assert property (s_wr_taken |=> !AWREADY && !WREADY ##1 BVALID)
    else $error("write response late or ready not dropped");
  a_write_release: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write channel not released");
  a_read_answer: assert property (s_rd_taken |=> RVALID && !ARREADY)
    else $error("read data late");
  a_read_release: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read channel not released");
  a_rdata_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_blocked_no_pending: assert property (IRQ_BLOCKED |-> IRQ_PENDING == '0)
    else $error("request while blocked");
  a_global_off_quiet: assert property (!GLOBAL_IRQ_ENABLE [*2] |-> IRQ_PENDING == '0)
    else $error("request with global enable off");
  a_base_legal_value: assert property (VECTOR_BASE_ADDR == '0 || VECTOR_BASE_ADDR == boot_start)
    else $error("vector base neither zero nor boot start");
  a_app_lock_blocks: assert property
    ((VECTOR_BASE_ADDR != '0 && APPLICATION_LOCK_BIT && !EXEC_IN_BOOT) [*2] |-> IRQ_BLOCKED)
    else $error("application lock did not block");
endmodule

bind eisv_top eisv_checker #(.ADDR_W(ADDR_W), .PC_WORD_W(PC_WORD_W),
  .BOOT_BASE_WORDS(BOOT_BASE_WORDS)) u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .EXEC_IN_BOOT(EXEC_IN_BOOT), .APPLICATION_LOCK_BIT(APPLICATION_LOCK_BIT),
  .BOOT_SIZE_SETTING(BOOT_SIZE_SETTING), .IRQ_PENDING(IRQ_PENDING),
  .IRQ_BLOCKED(IRQ_BLOCKED), .VECTOR_BASE_ADDR(VECTOR_BASE_ADDR));

// ==== tb/eisv_pins.sv ====
// Purpose: Model of the outside pin sources, pin change lines in the top bits.
// Assumes: Pins idle high as with pull-ups.
// Notes: A goal change is applied only after the current level has been held.
module eisv_pins (
  input logic clk,
  input logic rst,
  input logic [3:0] delay,
  input logic [16:0] goal,
  output logic [16:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] hold_reg;

  // each level held over 8 cycles, extra delay for slow sources
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '1;
      hold_reg <= '0;
    end else if (goal != pins && hold_reg >= 5'd8 + 5'(delay)) begin
      pins <= goal;
      hold_reg <= '0;
    end else if (hold_reg != 5'h1f) begin
      hold_reg <= hold_reg + 5'h1;
    end
  end
endmodule

// ==== tb/eisv_top_tb.sv ====
// Purpose: Self-checking bench for the interrupt sense and vector select block.
// Assumes: Reads are checked by a monitor against a queue of expectations.
// Notes: Pin activity comes from the eisv_pins model.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module eisv_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eisv_pkg::*;
  localparam logic [15:0] BOOT_W = 16'h0200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rnd = 32'haae7, v;
  logic awvalid = 0, wvalid = 0, arvalid = 0, gie = 1, clk_run = 1, instr_done = 0;
  logic in_boot = 0, app_lock = 0, boot_lock = 0, ack = 0;
  logic [1:0] size = 2'h3, m;
  logic [3:0] ack_id = '0, delay = '0;
  logic [7:0] e;
  logic [15:0] bs;
  logic [16:0] goal = '1;
  logic [33:0] e_m;
  logic [16:0] pins;
  logic awready, wready, bvalid, arready, rvalid, blocked, wake;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] pend;
  logic [15:0] vba;
  logic [33:0] expq[$];
  int error_cnt = 0, total_checks = 0, k, j;

  always #4 clk = ~clk;

  eisv_pins u_pins (.clk(clk), .rst(rst), .delay(delay), .goal(goal), .pins(pins));

  eisv_top #(.BOOT_BASE_WORDS(BOOT_W)) dut (.REF_CLK(clk), .RST(rst), .AWADDR(awaddr),
    .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1),
    .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1), .EXT_REQUEST_PINS(pins[7:0]),
    .PIN_CHANGE_LINES(pins[16:8]), .GLOBAL_IRQ_ENABLE(gie), .IO_CLK_RUN(clk_run),
    .INSTR_DONE(instr_done), .EXEC_IN_BOOT(in_boot), .APPLICATION_LOCK_BIT(app_lock),
    .BOOT_LOCK_BIT(boot_lock), .BOOT_SIZE_SETTING(size), .IRQ_ACK(ack), .IRQ_ACK_ID(ack_id),
    .IRQ_PENDING(pend), .IRQ_BLOCKED(blocked), .WAKE_REQUEST(wake), .VECTOR_BASE_ADDR(vba));

  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic timeout(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // Write one word; BREADY stays high so the response is taken when seen
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    awaddr <= {2'b00, i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    timeout(n, 40);
    `CHK(bresp, r)
  endtask

  // Read one word; the expected reply is queued for the monitor
  task automatic rd(input logic [7:0] i, input logic [7:0] x);
    int n = 0;
    expq.push_back({RESP_OKAY, 24'h0, x});
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    while (n < 40) begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    timeout(n, 40);
  endtask

  // Wait for the pin model to reach its goal, then for sync and flag stages
  task automatic settle();
    int n = 0;
    // Let the new goal land before comparing it with the pins
    do begin
      @(posedge clk);
      n++;
    end while (pins !== goal && n < 60);
    timeout(n, 60);
    repeat (6) @(posedge clk);
  endtask

  // Monitor: each read beat is matched against the oldest expectation
  always @(posedge clk) begin
    if (!rst && rvalid) begin
      e_m = expq.pop_front();
      `CHK({rresp, rdata}, e_m)
    end
  end

  initial begin
    v = xs();
    size = v[1:0];
    delay = v[5:2];
    bs = 16'h0 - (BOOT_W << (2'd3 - size));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IDX_MCU_GENERAL_CONTROL, RST_BYTE);
    rd(IDX_EXT_IRQ_SENSE_LOW, RST_BYTE);
    v = xs();
    wr(IDX_EXT_IRQ_SENSE_LOW, {24'h0, v[7:0]}, RESP_OKAY);
    rd(IDX_EXT_IRQ_SENSE_LOW, v[7:0]);
    wr(8'h00, 32'h1, RESP_DECERR);
    // mask, change sense, clear flags, unmask for each code
    for (int i = 0; i < 8; i++) begin
      m = i[1:0];
      wr(IDX_EXT_IRQ_MASK, 32'h0, RESP_OKAY);
      goal[7:0] <= 8'hff;
      settle();
      wr(IDX_EXT_IRQ_SENSE_LOW, 32'({4{m}}), RESP_OKAY);
      wr(IDX_EXT_IRQ_SENSE_HIGH, 32'({4{m}}), RESP_OKAY);
      clk_run <= i[2];
      wr(IDX_EXT_IRQ_FLAGS, 32'hff, RESP_OKAY);
      wr(IDX_EXT_IRQ_MASK, 32'hff, RESP_OKAY);
      goal[7:0] <= 8'h00;
      settle();
      e = (m == SENSE_ANY_EDGE || m == SENSE_FALLING) ? (i[2] ? 8'hff : 8'h0f) : 8'h00;
      rd(IDX_EXT_IRQ_FLAGS, e);
      `CHK(pend[7:0], (m == SENSE_LOW_LEVEL) ? 8'hff : e)
      `CHK(wake, m == SENSE_LOW_LEVEL)
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(pend[7:0], 8'h00)
      gie <= 1'b1;
    end
    v = xs();
    k = int'(v % 32'd8);
    j = (k + 1 + int'(xs() % 32'd7)) % 8;
    wr(IDX_PIN_CHANGE_MASK_ZERO, 32'h1 << k, RESP_OKAY);
    wr(IDX_PIN_CHANGE_MASK_ONE, 32'h1, RESP_OKAY);
    wr(IDX_PIN_CHANGE_FLAGS, 32'h3, RESP_OKAY);
    goal[8 + j] <= ~goal[8 + j];
    settle();
    rd(IDX_PIN_CHANGE_FLAGS, 8'h0);
    goal[8 + k] <= ~goal[8 + k];
    settle();
    rd(IDX_PIN_CHANGE_FLAGS, 8'h1);
    goal[16] <= ~goal[16];
    settle();
    rd(IDX_PIN_CHANGE_FLAGS, 8'h3);
    `CHK(pend[9:8], 2'b11)
    ack <= 1'b1;
    ack_id <= ID_PC_ZERO;
    @(posedge clk);
    ack <= 1'b0;
    rd(IDX_PIN_CHANGE_FLAGS, 8'h2);
    // enable then select, back to back inside the window
    wr(IDX_MCU_GENERAL_CONTROL, 32'h1, RESP_OKAY);
    wr(IDX_MCU_GENERAL_CONTROL, 32'h2, RESP_OKAY);
    `CHK(blocked, 1'b1)
    repeat (3) @(posedge clk);
    `CHK(vba, bs)
    `CHK(blocked, 1'b1)
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(blocked, 1'b0)
    rd(IDX_MCU_GENERAL_CONTROL, 8'h2);
    wr(IDX_MCU_GENERAL_CONTROL, 32'h3, RESP_OKAY);
    @(posedge clk);
    `CHK(blocked, 1'b1)
    repeat (8) @(posedge clk);
    `CHK(blocked, 1'b0)
    rd(IDX_MCU_GENERAL_CONTROL, 8'h2);
    wr(IDX_MCU_GENERAL_CONTROL, 32'h0, RESP_OKAY);
    rd(IDX_MCU_GENERAL_CONTROL, 8'h2);
    app_lock <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(blocked, 1'b1)
    in_boot <= 1'b1;
    boot_lock <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(blocked, 1'b0)
    // Vectors back to the application section while running boot code
    wr(IDX_MCU_GENERAL_CONTROL, 32'h1, RESP_OKAY);
    wr(IDX_MCU_GENERAL_CONTROL, 32'h0, RESP_OKAY);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(vba, 16'h0000)
    `CHK(blocked, 1'b1)
    in_boot <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(blocked, 1'b0)
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
